//--- core/hswe_pkg.sv
// constants for the hold, stop and wake event controller
package hswe_pkg;
    // event bit positions, shared by event flags, enables and interrupts
    localparam int EV_DIV0 = 0;
    localparam int EV_TMR0 = 1;
    localparam int EV_PORT = 2;
    localparam int EV_DIV1 = 4;
    localparam int EV_TMR1 = 7;
    // release cause bit positions
    localparam int HC_DIV0 = 0;
    localparam int HC_TMR0 = 1;
    localparam int HC_PORT = 2;
    localparam int HC_DIV1 = 4;
    localparam int HC_TMR1 = 5;
    // implemented bits of the 8-bit registers
    localparam logic [7:0] EV_MASK = 8'h97;
    localparam logic [7:0] HC_MASK = 8'h37;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [11:0] RST_PC = 12'h000;
    // write register selects on the register write port
    localparam logic [1:0] WSEL_HOLD_EN = 2'h0;
    localparam logic [1:0] WSEL_IRQ_EN = 2'h1;
    localparam logic [1:0] WSEL_PORT_EN = 2'h2;
    localparam logic [1:0] WSEL_STOP_EN = 2'h3;
    // power states of the core
    typedef enum logic [1:0] {st_run, st_hold, st_stop} power_state_t;
endpackage

//--- core/wake_edge_detect.sv
// wake input port synchroniser with change and falling edge detection
`timescale 1ns/1ps
module wake_edge_detect
    import hswe_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] changed,
    output logic [WIDTH-1:0] falling
);
    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;
    logic [WIDTH-1:0] prev;

    // two stage synchroniser then one history stage
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
            prev <= '0;
        end
        else
        begin
            sync_a <= pins;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    // compare synchronised sample against previous sample
    always_comb
    begin
        changed = sync_b ^ prev;
        falling = prev & ~sync_b;
    end
endmodule

//--- core/hold_stop_wake_event_control.sv
// event flags, interrupt, hold and stop control for the 4-bit core
// Functional notes
// - stop wake enable bit arms pin falling edge
// - hold halts execution, peripherals keep running
// - hold instruction; five release sources
// - hold release enable bit map
// - interrupt enable shares the same bit map
// - accepted interrupt clears only its event flag
// - taken interrupt blocks until enable rewrite or global interrupt on
// - port enable gates per-pin change events
// - release cause register, read as nibbles
// - release cause bit map
// - any cause bit set makes hold void
// - cause cleared by event clear or enable zero
// - event flags set by hardware events
// - reset clears event flags, cause and program counter; the interrupt gate resets open
// - interrupt when flag and enables set
// - interrupt in hold returns to hold after
// - stop instruction; wake resumes next instruction
`timescale 1ns/1ps
module hold_stop_wake_event_control
    import hswe_pkg::*;
#(
    parameter int PORT_W = 4
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic div0_overflow,
    input wire logic tmr0_underflow,
    input wire logic div1_overflow,
    input wire logic tmr1_underflow,
    input wire logic [PORT_W-1:0] wake_input_port,
    input wire logic reg_write,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic hold_op,
    input wire logic stop_op,
    input wire logic event_clear_op,
    input wire logic global_irq_on,
    input wire logic global_irq_off,
    input wire logic irq_ack,
    input wire logic [2:0] irq_ack_num,
    input wire logic return_from_sub,
    output logic [7:0] event_flags,
    output logic [7:0] hold_release_cause,
    output logic [3:0] cause_low_nibble,
    output logic [3:0] cause_high_nibble,
    output logic irq_req,
    output logic [2:0] irq_num,
    output logic cpu_halt,
    output logic hold_active,
    output logic stop_active,
    output logic osc_stop,
    output logic pc_clear
);
    logic [7:0] hold_release_enable;
    logic [7:0] interrupt_enable_mask;
    logic [PORT_W-1:0] port_change_enable;
    logic [PORT_W-1:0] stop_wake_enable;
    logic irq_gate;
    logic in_isr_from_hold;
    power_state_t pstate;
    logic [PORT_W-1:0] pin_changed;
    logic [PORT_W-1:0] pin_falling;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic [7:0] pending;
    logic [7:0] next_cause;
    logic [7:0] cause_keep;
    logic [2:0] next_num;
    logic wr_hold_en;
    logic wr_irq_en;
    logic cause_clear;
    logic stop_wake;
    logic hold_wake;

    wake_edge_detect #(.WIDTH(PORT_W)) u_edges
    (
        .mclk(mclk),
        .rst(rst),
        .pins(wake_input_port),
        .changed(pin_changed),
        .falling(pin_falling)
    );

    // maps an event bit position to its release cause position
    function automatic logic [7:0] ev_to_cause(input logic [7:0] ev);
        logic [7:0] c;
        c = '0;
        c[HC_DIV0] = ev[EV_DIV0];
        c[HC_TMR0] = ev[EV_TMR0];
        c[HC_PORT] = ev[EV_PORT];
        c[HC_DIV1] = ev[EV_DIV1];
        c[HC_TMR1] = ev[EV_TMR1];
        return c;
    endfunction

    // lowest pending interrupt number wins
    function automatic logic [2:0] pick_num(input logic [7:0] p);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (p[i])
            begin
                n = 3'(i);
            end
        end
        return n;
    endfunction

    // event sources and flag clears
    always_comb
    begin
        ev_set = '0;
        ev_set[EV_DIV0] = div0_overflow;
        ev_set[EV_TMR0] = tmr0_underflow;
        ev_set[EV_PORT] = |(pin_changed & port_change_enable);
        ev_set[EV_DIV1] = div1_overflow;
        ev_set[EV_TMR1] = tmr1_underflow;
        ev_clr = '0;
        if (irq_ack)
        begin
            ev_clr[irq_ack_num] = 1'b1;
        end
        if (event_clear_op)
        begin
            ev_clr = EV_MASK;
        end
    end

    // write decode, pending interrupts and wake decode
    always_comb
    begin
        wr_hold_en = reg_write && reg_sel == WSEL_HOLD_EN;
        wr_irq_en = reg_write && reg_sel == WSEL_IRQ_EN;
        cause_clear = event_clear_op || (wr_hold_en && reg_wdata == RST_BYTE);
        pending = event_flags & interrupt_enable_mask & EV_MASK;
        next_num = pick_num(pending);
        stop_wake = |(pin_falling & stop_wake_enable);
        hold_wake = |(ev_set & hold_release_enable & EV_MASK);
        next_cause = ev_to_cause(ev_set & hold_release_enable & EV_MASK);
        cause_keep = ev_to_cause(event_flags | hold_release_enable);
    end

    // write-only enable registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hold_release_enable <= RST_BYTE;
            interrupt_enable_mask <= RST_BYTE;
            port_change_enable <= RST_NIB;
            stop_wake_enable <= RST_NIB;
        end
        else if (reg_write)
        begin
            unique case (reg_sel)
                WSEL_HOLD_EN: hold_release_enable <= reg_wdata & EV_MASK;
                WSEL_IRQ_EN: interrupt_enable_mask <= reg_wdata & EV_MASK;
                WSEL_PORT_EN: port_change_enable <= reg_wdata[PORT_W-1:0];
                WSEL_STOP_EN: stop_wake_enable <= reg_wdata[PORT_W-1:0];
            endcase
        end
    end

    // event flags, set wins over clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            event_flags <= RST_BYTE;
        end
        else
        begin
            event_flags <= ((event_flags & ~ev_clr) | ev_set) & EV_MASK;
        end
    end

    // release cause register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hold_release_cause <= RST_BYTE;
        end
        else if (pstate == st_hold && hold_wake)
        begin
            hold_release_cause <= hold_release_cause | next_cause;
        end
        else if (cause_clear)
        begin
            hold_release_cause <= RST_BYTE;
        end
        else
        begin
            hold_release_cause <= hold_release_cause & cause_keep;
        end
    end

    // nibble views of the cause register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cause_low_nibble <= RST_NIB;
            cause_high_nibble <= RST_NIB;
        end
        else
        begin
            cause_low_nibble <= hold_release_cause[3:0];
            cause_high_nibble <= hold_release_cause[7:4];
        end
    end

    // global interrupt gate
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_gate <= 1'b1;
        end
        else if (irq_ack || global_irq_off)
        begin
            irq_gate <= 1'b0;
        end
        else if (global_irq_on || wr_irq_en)
        begin
            irq_gate <= 1'b1;
        end
    end

    // interrupt request to the core
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_req <= 1'b0;
            irq_num <= 3'h0;
        end
        else
        begin
            irq_req <= irq_gate && !irq_ack && !global_irq_off && (|pending) && pstate != st_stop;
            irq_num <= next_num;
        end
    end

    // power state machine
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pstate <= st_run;
        end
        else
        begin
            unique case (pstate)
                st_run:
                begin
                    if (return_from_sub && in_isr_from_hold && hold_release_cause == RST_BYTE)
                    begin
                        pstate <= st_hold;
                    end
                    else if (hold_op && hold_release_cause == RST_BYTE)
                    begin
                        pstate <= st_hold;
                    end
                    else if (stop_op)
                    begin
                        pstate <= st_stop;
                    end
                end
                st_hold:
                begin
                    if (hold_wake)
                    begin
                        pstate <= st_run;
                    end
                    else if (irq_ack)
                    begin
                        pstate <= st_run;
                    end
                end
                st_stop:
                begin
                    if (stop_wake)
                    begin
                        pstate <= st_run;
                    end
                end
            endcase
        end
    end

    // handler entered from hold, so its return goes back to hold
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            in_isr_from_hold <= 1'b0;
        end
        else if (pstate == st_hold && !hold_wake && irq_ack)
        begin
            in_isr_from_hold <= 1'b1;
        end
        else if (pstate == st_run && return_from_sub)
        begin
            in_isr_from_hold <= 1'b0;
        end
    end

    // state outputs
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cpu_halt <= 1'b0;
            hold_active <= 1'b0;
            stop_active <= 1'b0;
            osc_stop <= 1'b0;
        end
        else
        begin
            cpu_halt <= pstate != st_run;
            hold_active <= pstate == st_hold;
            stop_active <= pstate == st_stop;
            osc_stop <= pstate == st_stop;
        end
    end

    // program counter clear, held in reset, dropped on the first edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pc_clear <= 1'b1;
        end
        else
        begin
            pc_clear <= 1'b0;
        end
    end
endmodule

//--- verif/hswe_checker_properties.sv
// assertion checker on the event controller ports
`timescale 1ns/1ps
module hswe_checker
    import hswe_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic div0_overflow,
    input wire logic tmr0_underflow,
    input wire logic div1_overflow,
    input wire logic tmr1_underflow,
    input wire logic reg_write,
    input wire logic [1:0] reg_sel,
    input wire logic hold_op,
    input wire logic stop_op,
    input wire logic event_clear_op,
    input wire logic global_irq_on,
    input wire logic global_irq_off,
    input wire logic irq_ack,
    input wire logic [2:0] irq_ack_num,
    input wire logic [7:0] event_flags,
    input wire logic [7:0] hold_release_cause,
    input wire logic [3:0] cause_low_nibble,
    input wire logic [3:0] cause_high_nibble,
    input wire logic irq_req,
    input wire logic hold_active,
    input wire logic stop_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // gate reopeners and raw event pulses
    wire reopen = global_irq_on | (reg_write & (reg_sel == WSEL_IRQ_EN));
    wire any_ev = div0_overflow | tmr0_underflow | div1_overflow | tmr1_underflow;

    a_timer_flag_set: assert property (tmr0_underflow |=> event_flags[EV_TMR0])
        else $error("timer 0 underflow left its flag clear");
    a_flag_reserved_zero: assert property ((event_flags & ~EV_MASK) == 8'h00)
        else $error("reserved event flag bit set");
    a_cause_reserved_zero: assert property ((hold_release_cause & ~HC_MASK) == 8'h00)
        else $error("reserved cause bit set");
    a_nibble_copy: assert property ({cause_high_nibble, cause_low_nibble} == $past(hold_release_cause))
        else $error("cause nibbles do not follow the cause");
    a_hold_void: assert property (hold_op && hold_release_cause != 8'h00 && !hold_active |=> ##1 !hold_active)
        else $error("hold entered with a cause bit set");
    a_irq_gate_closed: assert property ((irq_ack || global_irq_off) && !reopen ##1 !reopen |=> !irq_req)
        else $error("interrupt raised while blocked");
    a_ack_clears_one: assert property (irq_ack && !event_clear_op && !any_ev |=>
        (event_flags & 8'hfb) == ($past(event_flags) & ~(8'h01 << $past(irq_ack_num)) & 8'hfb))
        else $error("acknowledge changed the wrong flags");
    a_stop_entry: assert property ($rose(stop_active) |-> $past(stop_op, 2))
        else $error("stop entered without a stop request");
endmodule

bind hold_stop_wake_event_control hswe_checker i_chk (.*);

//--- verif/periph_model.sv
// model of the timers, dividers and wake input pins
`timescale 1ns/1ps
module periph_model
    import hswe_pkg::*;
(
    input wire logic mclk,
    output logic div0_overflow,
    output logic tmr0_underflow,
    output logic div1_overflow,
    output logic tmr1_underflow,
    output logic [3:0] wake_input_port
);
    // quiet sources, pins idle high as with a pull-up
    initial
    begin
        {div0_overflow, tmr0_underflow, div1_overflow, tmr1_underflow} = 4'h0;
        wake_input_port = 4'hf;
    end
    // one-cycle pulse from one of the four count sources
    task automatic pulse(input int n);
        @(posedge mclk);
        div0_overflow <= (n == EV_DIV0);
        tmr0_underflow <= (n == EV_TMR0);
        div1_overflow <= (n == EV_DIV1);
        tmr1_underflow <= (n == EV_TMR1);
        @(posedge mclk);
        {div0_overflow, tmr0_underflow, div1_overflow, tmr1_underflow} <= 4'h0;
        #1;
    endtask
    // new pin levels just after an edge
    task automatic set_pins(input logic [3:0] v);
        @(posedge mclk);
        wake_input_port <= v;
        #1;
    endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the hold, stop and wake event controller
`timescale 1ns/1ps
module tb_top
    import hswe_pkg::*;
;
    localparam int OP_HOLD = 0, OP_STOP = 1, OP_CLR = 2, OP_ON = 3, OP_OFF = 4, OP_RET = 5;
    logic mclk = 1'b0, rst = 1'b1, reg_write = 1'b0, irq_ack = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [7:0] reg_wdata = 8'h00, event_flags, hold_release_cause, acc = 8'h00;
    logic [2:0] irq_ack_num = 3'h0, irq_num;
    logic [5:0] ops = 6'h00;
    logic [3:0] wake_input_port, cause_low_nibble, cause_high_nibble;
    logic div0_overflow, tmr0_underflow, div1_overflow, tmr1_underflow;
    logic irq_req, cpu_halt, hold_active, stop_active, osc_stop, pc_clear;
    wire hold_op, stop_op, event_clear_op, global_irq_on, global_irq_off, return_from_sub;
    int miscompares = 0, cmp_count = 0;
    int src[4] = '{EV_DIV0, EV_TMR0, EV_DIV1, EV_TMR1};
    int hcb[4] = '{HC_DIV0, HC_TMR0, HC_DIV1, HC_TMR1};
    // core instruction pulses, one bit each
    assign {return_from_sub, global_irq_off, global_irq_on, event_clear_op, stop_op, hold_op} = ops;

    always #12.5 mclk = ~mclk;

    hold_stop_wake_event_control i_dut (.*);
    periph_model i_periph (.*);

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic op(input int k);
        @(posedge mclk);
        ops <= 6'h01 << k;
        @(posedge mclk);
        ops <= 6'h00;
        #1;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_sel <= sel;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic ack(input logic [2:0] n);
        @(posedge mclk);
        irq_ack <= 1'b1;
        irq_ack_num <= n;
        @(posedge mclk);
        irq_ack <= 1'b0;
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        chk("pc_clear", 8'h01, pc_clear);
        rst <= 1'b0;
        tick(2);
        chk("flags", 8'h00, event_flags);
        chk("pc_clear", 8'h00, pc_clear);
        for (int i = 0; i < 4; i++)
        begin
            i_periph.pulse(src[i]);
            acc = acc | (8'h01 << src[i]);
            chk("flags", acc, event_flags);
        end
        op(OP_CLR);
        chk("flags", 8'h00, event_flags);
        i_periph.pulse(EV_DIV1);
        i_periph.pulse(EV_TMR1);
        tick(1);
        chk("irq_req", 8'h00, irq_req);
        wr(WSEL_IRQ_EN, 8'h80);
        tick(1);
        chk("irq_req", 8'h01, irq_req);
        chk("irq_num", 8'(EV_TMR1), irq_num);
        ack(3'(EV_TMR1));
        chk("flags", 8'h10, event_flags);
        tick(1);
        chk("irq_req", 8'h00, irq_req);
        wr(WSEL_IRQ_EN, 8'h10);
        tick(1);
        chk("irq_num", 8'(EV_DIV1), irq_num);
        op(OP_OFF);
        tick(1);
        chk("irq_req", 8'h00, irq_req);
        op(OP_ON);
        tick(1);
        chk("irq_req", 8'h01, irq_req);
        // interrupt taken in hold, back to hold on return
        op(OP_HOLD);
        tick(2);
        chk("hold_active", 8'h01, hold_active);
        ack(3'(EV_DIV1));
        tick(2);
        chk("hold_active", 8'h00, hold_active);
        op(OP_RET);
        tick(2);
        chk("hold_active", 8'h01, hold_active);
        for (int i = 0; i < 4; i++)
        begin
            wr(WSEL_HOLD_EN, 8'h01 << src[i]);
            op(OP_HOLD);
            tick(2);
            chk("cpu_halt", 8'h01, cpu_halt);
            i_periph.pulse(src[i]);
            chk("cause", 8'h01 << hcb[i], hold_release_cause);
            tick(1);
            chk("hold_active", 8'h00, hold_active);
            chk("nibbles", 8'h01 << hcb[i], {cause_high_nibble, cause_low_nibble});
            op(OP_HOLD);
            tick(2);
            chk("hold_active", 8'h00, hold_active);
            if (i[0])
                wr(WSEL_HOLD_EN, 8'h00);
            else
                op(OP_CLR);
            chk("cause", 8'h00, hold_release_cause);
        end
        op(OP_CLR);
        wr(WSEL_PORT_EN, 8'h01);
        i_periph.set_pins(4'hd);
        tick(5);
        chk("flags", 8'h00, event_flags);
        wr(WSEL_HOLD_EN, 8'h04);
        op(OP_HOLD);
        i_periph.set_pins(4'hc);
        tick(5);
        chk("flags", 8'h04, event_flags);
        chk("cause", 8'h04, hold_release_cause);
        // cause bit stays while its flag is set, goes once flag and enable are both clear
        wr(WSEL_HOLD_EN, 8'h01);
        chk("cause", 8'h04, hold_release_cause);
        wr(WSEL_IRQ_EN, 8'h04);
        tick(1);
        chk("irq_req", 8'h01, irq_req);
        chk("irq_num", 8'(EV_PORT), irq_num);
        ack(3'(EV_PORT));
        tick(1);
        chk("cause", 8'h00, hold_release_cause);
        op(OP_CLR);
        wr(WSEL_STOP_EN, 8'h02);
        op(OP_STOP);
        tick(2);
        chk("osc_stop", 8'h01, osc_stop);
        i_periph.set_pins(4'ha);
        tick(6);
        chk("stop_active", 8'h01, stop_active);
        i_periph.set_pins(4'h8);
        tick(6);
        chk("stop_active", 8'h00, stop_active);
        finish_test();
    end

    // watchdog against a hang
    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        finish_test();
    end
endmodule
